//--- pkg/pasc_pkg.sv
// package for the partner ability, expansion and vendor configuration register bank
// ---------------------------------------------------------------------------
// Contract
// - partner ability register is filled from the received base page
// - bit 15 reports partner next page, read-only, resets 0
// - acknowledge bit driven by negotiation logic only; management never writes it
// - bit 13 reports partner remote fault
// - reserved bits 12:11 and expansion 15:5 read zero, writes ignored
// - bit 10 reports partner pause ability
// - bits 9:5 report partner T4, TX full, TX half, 10 full, 10 half
// - bits 4:0 hold partner selector field, read-only, reset zero
// - expansion bit 4 latches parallel detection fault
// - expansion bit 3 reports partner next page capability
// - expansion bit 2 local next page capability is always zero
// - expansion bit 1 sets on new page, clears on expansion register read
// - expansion bit 0 reports partner negotiation capable, resets zero
// - config bit 15 bypasses block encoder and decoder
// - config bit 14 bypasses scrambler and descrambler
// - config bit 13 bypasses whole receive and transmit symbol path
// - config bit 12 forces internal signal-detect active, debug only
// - config bit 11 captures repeater/node strap at reset, stays writable
// - config bit 10 read-write, resets 1, selects 100BASE-TX
// - config bit 8 read-write, selects normal or reduced MII
// - latch-high bits hold until register read or reset
// ---------------------------------------------------------------------------
package pasc_pkg;

  // ---------------------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------------------
  localparam int unsigned   ADDR_W          = 5;
  localparam int unsigned   DATA_W          = 16;
  localparam logic [4:0]    ADDR_PARTNER    = 5'h05;
  localparam logic [4:0]    ADDR_EXPANSION  = 5'h06;
  localparam logic [4:0]    ADDR_CONFIG     = 5'h10;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned   PA_NEXT_PAGE    = 15;
  localparam int unsigned   PA_ACK          = 14;
  localparam int unsigned   PA_REMOTE_FAULT = 13;
  localparam int unsigned   PA_PAUSE        = 10;
  localparam int unsigned   PA_ABIL_LSB     = 5;
  localparam int unsigned   PA_SEL_LSB      = 0;
  localparam int unsigned   EX_PD_FAULT     = 4;
  localparam int unsigned   EX_PARTNER_NP   = 3;
  localparam int unsigned   EX_LOCAL_NP     = 2;
  localparam int unsigned   EX_PAGE_RX      = 1;
  localparam int unsigned   EX_PARTNER_AN   = 0;
  localparam int unsigned   CF_BYP_BLOCK    = 15;
  localparam int unsigned   CF_BYP_SCR      = 14;
  localparam int unsigned   CF_BYP_SYM      = 13;
  localparam int unsigned   CF_FORCE_SD     = 12;
  localparam int unsigned   CF_REPEATER     = 11;
  localparam int unsigned   CF_SPEED_TX     = 10;
  localparam int unsigned   CF_RESERVED9    = 9;
  localparam int unsigned   CF_RMII         = 8;

  // ---------------------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [15:0]   PARTNER_RESET   = 16'h0000;
  localparam logic [15:0]   PARTNER_MASK    = 16'he7ff;
  localparam logic [15:0]   EXPANSION_MASK  = 16'h001f;
  localparam logic [15:0]   CONFIG_WR_MASK  = 16'hfd00;
  localparam logic          SPEED_TX_RESET  = 1'b1;
  localparam logic          RESERVED9_VALUE = 1'b1;

  // received base page from the negotiation logic
  typedef struct packed {
    logic        next_page;
    logic        ack;
    logic        remote_fault;
    logic        pause_ability;
    logic [4:0]  abilities;
    logic [4:0]  selector;
  } pasc_page_t;

  // coding path controls to the datapath
  typedef struct packed {
    logic bypass_block_code;
    logic bypass_scrambling;
    logic bypass_symbol_path;
    logic force_line_signal_ok;
    logic repeater_mode;
    logic speed_tx;
    logic rmii_select;
  } pasc_ctrl_t;

  typedef enum logic [1:0] {
    PASC_ST_STRAP = 2'b00,
    PASC_ST_RUN   = 2'b01
  } pasc_state_t;

endpackage : pasc_pkg

//--- logic/pasc_read_mux.sv
// registered read data selection for the register bank
`timescale 1ns/100ps
`default_nettype none
module pasc_read_mux
  import pasc_pkg::*;
(
  input  wire logic              clock,     // core clock
  input  wire logic              rst_n,     // async reset, active low
  input  wire logic [ADDR_W-1:0] rd_addr,   // register address
  input  wire logic [15:0]       partner,   // partner ability image
  input  wire logic [15:0]       expansion, // expansion image
  input  wire logic [15:0]       config_v,  // configuration image
  output logic      [15:0]       rd_data    // registered read data
);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else begin
      case (rd_addr)
        ADDR_PARTNER:   rd_data <= partner & PARTNER_MASK;
        ADDR_EXPANSION: rd_data <= expansion & EXPANSION_MASK;
        ADDR_CONFIG:    rd_data <= config_v;
        default:        rd_data <= 16'h0000;
      endcase
    end
  end

endmodule : pasc_read_mux
`default_nettype wire

//--- logic/pasc_regs.sv
// partner ability, expansion status and vendor configuration registers
`timescale 1ns/100ps
`default_nettype none
module pasc_regs
  import pasc_pkg::*;
(
  input  wire logic              clock,          // core clock, 200 MHz
  input  wire logic              rst_n,          // async reset, active low
  input  wire logic              mgmt_rd,        // management read strobe
  input  wire logic              mgmt_wr,        // management write strobe
  input  wire logic [ADDR_W-1:0] mgmt_addr,      // register address
  input  wire logic [15:0]       mgmt_wdata,     // write data
  output logic      [15:0]       mgmt_rdata,     // read data, valid cycle after strobe
  input  wire pasc_page_t        page_data,      // received base page
  input  wire logic              page_valid,     // pulse: new page received
  input  wire logic              pd_fault,       // pulse: parallel detection fault
  input  wire logic              partner_an_able,// level: partner negotiates
  input  wire logic              strap_repeater, // repeater/node strap level
  input  wire logic              strap_rmii,     // reduced MII strap level
  output pasc_ctrl_t             ctrl            // coding path controls
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  pasc_page_t  page_reg;
  logic        an_able_reg;
  logic        pd_fault_reg;
  logic        page_rx_reg;
  logic [15:8] cfg_reg;
  pasc_state_t state_reg;
  logic [15:0] partner_v;
  logic [15:0] expansion_v;
  logic [15:0] config_v;
  logic        exp_read;
  logic        cfg_write;

  assign exp_read  = mgmt_rd && (mgmt_addr == ADDR_EXPANSION);
  assign cfg_write = mgmt_wr && (mgmt_addr == ADDR_CONFIG);

  // ---------------------------------------------------------------------------
  // partner page capture
  // ---------------------------------------------------------------------------
  // management writes to the partner register never reach here; its image is
  // only loaded from the negotiation logic, acknowledge included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= pasc_page_t'(PARTNER_RESET[$bits(pasc_page_t)-1:0]);
    end else if (page_valid) begin
      page_reg <= page_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      an_able_reg <= 1'b0;
    end else begin
      an_able_reg <= partner_an_able;
    end
  end

  // ---------------------------------------------------------------------------
  // latch-high flags: a set in the read cycle wins over the clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_fault_reg <= 1'b0;
    end else if (pd_fault) begin
      pd_fault_reg <= 1'b1;
    end else if (exp_read) begin
      pd_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      page_rx_reg <= 1'b0;
    end else if (page_valid) begin
      page_rx_reg <= 1'b1;
    end else if (exp_read) begin
      page_rx_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration; straps are caught on the first clock after reset release
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PASC_ST_STRAP;
    end else begin
      case (state_reg)
        PASC_ST_STRAP: state_reg <= PASC_ST_RUN;
        PASC_ST_RUN:   state_reg <= PASC_ST_RUN;
        default:       state_reg <= PASC_ST_STRAP;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg                <= 8'h00;
      cfg_reg[CF_SPEED_TX]   <= SPEED_TX_RESET;
      cfg_reg[CF_RESERVED9]  <= RESERVED9_VALUE;
    end else if (state_reg == PASC_ST_STRAP) begin
      cfg_reg[CF_REPEATER]   <= strap_repeater;
      cfg_reg[CF_RMII]       <= strap_rmii;
    end else if (cfg_write) begin
      // bit 9 is outside the write mask and keeps its fixed value
      cfg_reg <= (mgmt_wdata[15:8] & CONFIG_WR_MASK[15:8])
               | (cfg_reg & ~CONFIG_WR_MASK[15:8]);
    end
  end

  // ---------------------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------------------
  always_comb begin
    partner_v                   = 16'h0000;
    partner_v[PA_NEXT_PAGE]     = page_reg.next_page;
    partner_v[PA_ACK]           = page_reg.ack;
    partner_v[PA_REMOTE_FAULT]  = page_reg.remote_fault;
    partner_v[PA_PAUSE]         = page_reg.pause_ability;
    partner_v[PA_ABIL_LSB+:5]   = page_reg.abilities;
    partner_v[PA_SEL_LSB+:5]    = page_reg.selector;
  end

  always_comb begin
    expansion_v                 = 16'h0000;
    expansion_v[EX_PD_FAULT]    = pd_fault_reg;
    expansion_v[EX_PARTNER_NP]  = page_reg.next_page;
    expansion_v[EX_LOCAL_NP]    = 1'b0;
    expansion_v[EX_PAGE_RX]     = page_rx_reg;
    expansion_v[EX_PARTNER_AN]  = an_able_reg;
  end

  assign config_v = {cfg_reg, 8'h00};

  pasc_read_mux u_read_mux (
    .clock     (clock),
    .rst_n     (rst_n),
    .rd_addr   (mgmt_addr),
    .partner   (partner_v),
    .expansion (expansion_v),
    .config_v  (config_v),
    .rd_data   (mgmt_rdata)
  );

  // ---------------------------------------------------------------------------
  // controls to the coding path
  // ---------------------------------------------------------------------------
  // the symbol path bypass implies both narrower bypasses downstream
  always_comb begin
    ctrl.bypass_block_code    = cfg_reg[CF_BYP_BLOCK] | cfg_reg[CF_BYP_SYM];
    ctrl.bypass_scrambling    = cfg_reg[CF_BYP_SCR] | cfg_reg[CF_BYP_SYM];
    ctrl.bypass_symbol_path   = cfg_reg[CF_BYP_SYM];
    ctrl.force_line_signal_ok = cfg_reg[CF_FORCE_SD];
    ctrl.repeater_mode        = cfg_reg[CF_REPEATER];
    ctrl.speed_tx             = cfg_reg[CF_SPEED_TX];
    ctrl.rmii_select          = cfg_reg[CF_RMII];
  end

endmodule : pasc_regs
`default_nettype wire

//--- sim/pasc_regs_asserts.sv
// assertion checker for the register bank ports
`timescale 1ns/100ps
`default_nettype none
module pasc_regs_asserts
  import pasc_pkg::*;
(
  input wire logic              clock,           // core clock
  input wire logic              rst_n,           // async reset
  input wire logic              mgmt_rd,         // read strobe
  input wire logic              mgmt_wr,         // write strobe
  input wire logic [ADDR_W-1:0] mgmt_addr,       // address
  input wire logic [15:0]       mgmt_wdata,      // write data
  input wire logic [15:0]       mgmt_rdata,      // read data
  input wire pasc_page_t        page_data,       // base page
  input wire logic              page_valid,      // page strobe
  input wire logic              pd_fault,        // fault strobe
  input wire logic              partner_an_able, // partner negotiates
  input wire logic              strap_repeater,  // strap
  input wire logic              strap_rmii,      // strap
  input wire pasc_ctrl_t        ctrl             // controls
);
  pasc_page_t  pg_q;
  logic [15:0] wd_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= '0;
      wd_q <= 16'h0000;
    end else begin
      wd_q <= mgmt_wdata;
      if (page_valid) pg_q <= page_data;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_page_idle;
    page_valid ##1 !page_valid;
  endsequence
  sequence s_exp_read;
    mgmt_rd && mgmt_addr == ADDR_EXPANSION && !page_valid && !pd_fault;
  endsequence
  a_page_load:
  assert property (s_page_idle ##1 (!page_valid && mgmt_addr == ADDR_PARTNER)
    |=> mgmt_rdata == {pg_q[13:11], 2'b00, pg_q[10:0]}) else $error("partner image wrong");
  a_flag_clear:
  assert property (s_exp_read ##1 (mgmt_addr == ADDR_EXPANSION && !page_valid && !pd_fault)
    |=> !mgmt_rdata[4] && !mgmt_rdata[1]) else $error("flags not cleared by read");
  a_fault_hold:
  assert property (pd_fault ##1 (!mgmt_rd && mgmt_addr == ADDR_EXPANSION)[*3]
    |=> mgmt_rdata[4]) else $error("fault flag lost");
  a_an_able:
  assert property ($past(rst_n) && mgmt_addr == ADDR_EXPANSION
    |=> mgmt_rdata[0] == $past(partner_an_able, 2)) else $error("negotiation bit wrong");
  a_cfg_write:
  assert property (mgmt_wr && mgmt_addr == ADDR_CONFIG && $past(rst_n) |=> ctrl ==
    {wd_q[15] | wd_q[13], wd_q[14] | wd_q[13], wd_q[13:10], wd_q[8]}) else $error("ctrl wrong");
  a_strap_take:
  assert property ($rose(rst_n) |=> ctrl.repeater_mode == $past(strap_repeater)
    && ctrl.rmii_select == $past(strap_rmii) && ctrl.speed_tx) else $error("strap not taken");
  a_cfg_fixed:
  assert property (mgmt_addr == ADDR_CONFIG |=> mgmt_rdata[9] && mgmt_rdata[7:0] == 8'h00)
    else $error("config fixed bits wrong");
  a_pa_rsvd:
  assert property (mgmt_addr == ADDR_PARTNER |=> mgmt_rdata[12:11] == 2'b00)
    else $error("partner reserved set");
  a_ex_rsvd:
  assert property (mgmt_addr == ADDR_EXPANSION |=> mgmt_rdata[15:5] == '0 && !mgmt_rdata[2])
    else $error("expansion reserved set");
  a_page_set_wins:
  assert property ((mgmt_rd && mgmt_addr == ADDR_EXPANSION && page_valid)
    ##1 (!mgmt_rd && mgmt_addr == ADDR_EXPANSION) |=> mgmt_rdata[1])
    else $error("page flag lost to same cycle read");
  a_fault_set_wins:
  assert property ((mgmt_rd && mgmt_addr == ADDR_EXPANSION && pd_fault)
    ##1 (!mgmt_rd && mgmt_addr == ADDR_EXPANSION) |=> mgmt_rdata[4])
    else $error("fault flag lost to same cycle read");
endmodule : pasc_regs_asserts
bind pasc_regs pasc_regs_asserts u_chk (.clock(clock), .rst_n(rst_n), .mgmt_rd(mgmt_rd),
  .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .page_data(page_data), .page_valid(page_valid), .pd_fault(pd_fault),
  .partner_an_able(partner_an_able), .strap_repeater(strap_repeater),
  .strap_rmii(strap_rmii), .ctrl(ctrl));
`default_nettype wire

//--- sim/pasc_mgmt_model.sv
// station management model driving register reads and writes
`timescale 1ns/100ps
`default_nettype none
module pasc_mgmt_model
  import pasc_pkg::*;
(
  input  wire logic              clock,      // core clock
  output logic                   mgmt_rd,    // read strobe
  output logic                   mgmt_wr,    // write strobe
  output logic      [ADDR_W-1:0] mgmt_addr,  // address
  output logic      [15:0]       mgmt_wdata, // write data
  input  wire logic [15:0]       mgmt_rdata  // read data
);
  initial begin
    mgmt_rd    = 1'b0;
    mgmt_wr    = 1'b0;
    mgmt_addr  = '0;
    mgmt_wdata = 16'h0000;
  end
  // writes to the partner register exist only to probe refusal
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge clock);
    mgmt_wr    = 1'b1;
    mgmt_addr  = a;
    mgmt_wdata = d;
    @(negedge clock);
    mgmt_wr    = 1'b0;
    mgmt_wdata = ~d; // stale data must not look valid
  endtask : write_reg
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(negedge clock);
    mgmt_rd   = 1'b1;
    mgmt_addr = a;
    @(negedge clock);
    mgmt_rd   = 1'b0;
    d         = mgmt_rdata;
  endtask : read_reg
endmodule : pasc_mgmt_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the partner, expansion and config registers
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pasc_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              mgmt_rd, mgmt_wr, page_valid = 1'b0, pd_fault = 1'b0, an_able = 1'b0;
  logic              strap_rep = 1'b1, strap_rmii = 1'b0;
  logic [ADDR_W-1:0] mgmt_addr;
  logic [15:0]       mgmt_wdata, mgmt_rdata, rd;
  pasc_page_t        page_data = '0;
  pasc_ctrl_t        ctrl;
  int                n_errors = 0, checked = 0, cycles = 0;
  always #2.5 clock = ~clock;
  pasc_mgmt_model mgmt (.clock(clock), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
  pasc_regs uut (.clock(clock), .rst_n(rst_n), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .page_data(page_data), .page_valid(page_valid), .pd_fault(pd_fault),
    .partner_an_able(an_able), .strap_repeater(strap_rep), .strap_rmii(strap_rmii),
    .ctrl(ctrl));
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin // far beyond the roughly one hundred cycles the tests need
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
    mgmt.read_reg(a, rd);
    check(what, rd, exp);
  endtask : rd_chk
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic do_reset(input logic rep, input logic rmii);
    @(negedge clock);
    rst_n      = 1'b0;
    strap_rep  = rep;
    strap_rmii = rmii;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask : do_reset
  task automatic t_reset();
    check("ctrl reset", {9'h0, ctrl}, {13'h0, strap_rep, 1'b1, strap_rmii});
    rd_chk("config reset", ADDR_CONFIG, {4'h0, strap_rep, 2'b11, strap_rmii, 8'h00});
    rd_chk("partner reset", ADDR_PARTNER, 16'h0000);
    rd_chk("expansion reset", ADDR_EXPANSION, 16'h0000);
  endtask : t_reset
  task automatic t_page();
    pasc_page_t pg [2];
    pg[0] = 14'h3fff;
    pg[1] = 14'h0aaa;
    foreach (pg[i]) begin
      an_able = (i == 0);
      @(negedge clock);
      page_data  = pg[i];
      page_valid = 1'b1;
      @(negedge clock);
      page_valid = 1'b0;
      rd_chk("partner", ADDR_PARTNER, {pg[i][13:11], 2'b00, pg[i][10:0]});
      mgmt.write_reg(ADDR_PARTNER, 16'h0000);
      rd_chk("partner kept", ADDR_PARTNER, {pg[i][13:11], 2'b00, pg[i][10:0]});
      rd_chk("new page", ADDR_EXPANSION, {12'h0, pg[i][13], 2'b01, i == 0});
      rd_chk("page cleared", ADDR_EXPANSION, {12'h0, pg[i][13], 2'b00, i == 0});
    end
  endtask : t_page
  task automatic t_fault();
    @(negedge clock);
    pd_fault = 1'b1;
    @(negedge clock);
    pd_fault = 1'b0;
    repeat (4) @(negedge clock);
    mgmt.write_reg(ADDR_EXPANSION, 16'hffff);
    rd_chk("fault latched", ADDR_EXPANSION, 16'h0010);
    rd_chk("fault cleared", ADDR_EXPANSION, 16'h0000);
    // both flags set in the very cycle that the read would clear them
    fork
      mgmt.read_reg(ADDR_EXPANSION, rd);
      begin
        @(negedge clock);
        page_valid = 1'b1;
        pd_fault   = 1'b1;
        @(negedge clock);
        page_valid = 1'b0;
        pd_fault   = 1'b0;
      end
    join
    check("flags before set", rd, 16'h0000);
    rd_chk("set wins over read", ADDR_EXPANSION, 16'h0012);
    rd_chk("flags read clear", ADDR_EXPANSION, 16'h0000);
  endtask : t_fault
  task automatic t_config();
    logic [15:0] w [5];
    w = '{16'hffff, 16'h0000, 16'h2000, 16'h5500, 16'h8a00};
    foreach (w[i]) begin
      mgmt.write_reg(ADDR_CONFIG, w[i]);
      check("ctrl", {9'h0, ctrl}, {9'h0, w[i][15] | w[i][13], w[i][14] | w[i][13],
        w[i][13:10], w[i][8]});
      rd_chk("config", ADDR_CONFIG, (w[i] & 16'hfd00) | 16'h0200);
    end
    rd_chk("unmapped", 5'h1f, 16'h0000);
  endtask : t_config
  initial begin
    do_reset(1'b1, 1'b0);
    t_reset();
    t_page();
    t_fault();
    t_config();
    do_reset(1'b0, 1'b1);
    t_reset();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
